/* src/vgp_pkg.sv */
// package: constants, types and field assembly for the coefficient bank regs
package vgp_pkg;

    // control port geometry
    localparam int VGP_AW        = 8;
    localparam int VGP_DW        = 8;
    localparam int VGP_BANK_REGS = 9;
    localparam int VGP_SEED_REGS = 4;
    localparam int VGP_IDX_W     = 4;

    // bank 0 register offsets
    localparam logic [7:0] MSYNC_GAIN_LOW    = 8'h17;
    localparam logic [7:0] LUMA_GAIN_LOW     = 8'h18;
    localparam logic [7:0] U_GAIN_LOW        = 8'h19;
    localparam logic [7:0] V_GAIN_LOW        = 8'h1A;
    localparam logic [7:0] GAIN_HIGH_BITS    = 8'h1B;
    localparam logic [7:0] LUMA_OFFSET_LOW   = 8'h1C;
    localparam logic [7:0] OFFSET_MSYNC_HIGH = 8'h1D;
    localparam logic [7:0] PHASE_LOW_VFLIP   = 8'h1E;
    localparam logic [7:0] PHASE_HIGH        = 8'h1F;
    localparam logic [7:0] BANK0_BASE        = 8'h17;
    localparam logic [7:0] BANK1_BASE        = 8'h27;

    // subcarrier seed offsets
    localparam logic [7:0] SUBCARRIER_SEED_BITS_3_0   = 8'h20;
    localparam logic [7:0] SUBCARRIER_SEED_BITS_11_4  = 8'h21;
    localparam logic [7:0] SUBCARRIER_SEED_BITS_19_12 = 8'h22;
    localparam logic [7:0] SUBCARRIER_SEED_BITS_27_20 = 8'h23;
    localparam logic [7:0] SEED_BASE                  = 8'h20;

    // values after reset and writable bit masks (reserved bits store zero)
    localparam logic [7:0] VGP_REG_RESET = 8'h00;
    localparam logic [VGP_BANK_REGS-1:0][7:0] BANK_WMASK =
        {8'hFF, 8'hFF, 8'h07, 8'hFF, 8'hFB, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [VGP_SEED_REGS-1:0][7:0] SEED_WMASK =
        {8'hFF, 8'hFF, 8'hFF, 8'hF0};

    // field positions inside the split registers
    localparam int LUMA_HI_LSB   = 6;
    localparam int U_HI_LSB      = 3;
    localparam int V_HI_LSB      = 0;
    localparam int MSYNC_HI_LSB  = 0;
    localparam int OFFSET_HI_BIT = 2;
    localparam int PHASE_LO_LSB  = 1;
    localparam int VFLIP_BIT     = 0;
    localparam int SEED_LO_LSB   = 4;
    localparam int SEED_W        = 28;

    typedef logic [VGP_BANK_REGS-1:0][7:0] vgp_bank_regs_t;
    typedef logic [VGP_SEED_REGS-1:0][7:0] vgp_seed_regs_t;

    typedef struct packed {
        logic [9:0]  mixed_sync_scale;
        logic [9:0]  luma_gain_coef;
        logic [10:0] u_chroma_gain;
        logic [9:0]  v_chroma_gain;
        logic [8:0]  luma_rgb_offset;
        logic [14:0] system_phase_offset;
        logic        pal_v_sign_flip;
    } vgp_coef_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vgp_ctl_req_t;

    typedef struct packed {
        logic       rvalid;
        logic [7:0] rdata;
    } vgp_ctl_rsp_t;

    typedef struct packed {
        vgp_seed_regs_t    seed;
        vgp_coef_t         coef_out;
        logic [SEED_W-1:0] seed_out;
        logic              bank_out;
        vgp_ctl_rsp_t      rsp;
    } vgp_regs_state_t;

    // index of a register within a block starting at base
    function automatic logic [VGP_IDX_W-1:0] vgp_index(
        input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] diff;
        diff = addr - base;
        return diff[VGP_IDX_W-1:0];
    endfunction : vgp_index

    function automatic logic vgp_in_range(
        input logic [7:0] addr, input logic [7:0] base, input int n);
        return (addr >= base) && ({24'h0, addr} < {24'h0, base} + n);
    endfunction : vgp_in_range

    // split fields joined into whole coefficients
    function automatic vgp_coef_t vgp_assemble(input vgp_bank_regs_t r);
        vgp_coef_t c;
        c.mixed_sync_scale = {r[6][MSYNC_HI_LSB +: 2], r[0]};
        c.luma_gain_coef   = {r[4][LUMA_HI_LSB +: 2], r[1]};
        c.u_chroma_gain    = {r[4][U_HI_LSB +: 3], r[2]};
        c.v_chroma_gain    = {r[4][V_HI_LSB +: 2], r[3]};
        c.luma_rgb_offset  = {r[6][OFFSET_HI_BIT], r[5]};
        c.system_phase_offset = {r[8], r[7][PHASE_LO_LSB +: 7]};
        c.pal_v_sign_flip  = r[7][VFLIP_BIT];
        return c;
    endfunction : vgp_assemble

endpackage : vgp_pkg

/* src/vgp_coef_bank.sv */
// one stored set of processing coefficients
`timescale 1ns/1ps
`default_nettype none
module vgp_coef_bank
    import vgp_pkg::*;
(
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    nrst,
    // write side
    input  wire logic                    wr_en,
    input  wire logic [VGP_IDX_W-1:0]    wr_idx,
    input  wire logic [VGP_DW-1:0]       wr_data,
    // stored bytes and joined fields
    output var  vgp_pkg::vgp_bank_regs_t regs,
    output var  vgp_pkg::vgp_coef_t      coef
);
    vgp_bank_regs_t next_regs;

    // writes into one bank never disturb the other, the pin only selects
    always_comb begin
        next_regs = regs;
        if (wr_en) begin
            next_regs[wr_idx] = wr_data & BANK_WMASK[wr_idx];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            regs <= {VGP_BANK_REGS{VGP_REG_RESET}};
        end else begin
            regs <= next_regs;
        end
    end

    always_comb begin
        coef = vgp_assemble(regs);
    end
endmodule : vgp_coef_bank
`default_nettype wire

/* src/vgp_regs.sv */
// coefficient bank and subcarrier seed registers behind the control port
`timescale 1ns/1ps
`default_nettype none
module vgp_regs
    import vgp_pkg::*;
(
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    // bank select pin
    input  wire logic                 buffer_sel,
    // control port
    input  wire vgp_pkg::vgp_ctl_req_t ctl_req,
    output var  vgp_pkg::vgp_ctl_rsp_t ctl_rsp,
    // values applied to the processing path
    output var  vgp_pkg::vgp_coef_t   coef_out,
    output var  logic [27:0]          seed_out,
    output var  logic                 bank_out
);
    import vgp_pkg::*;

    vgp_regs_state_t          st;
    vgp_regs_state_t          next_st;
    vgp_bank_regs_t           b0_regs;
    vgp_bank_regs_t           b1_regs;
    vgp_coef_t                b0_coef;
    vgp_coef_t                b1_coef;
    logic                     b0_hit;
    logic                     b1_hit;
    logic                     seed_hit;
    logic [VGP_IDX_W-1:0]     b0_idx;
    logic [VGP_IDX_W-1:0]     b1_idx;
    logic [VGP_IDX_W-1:0]     seed_idx;
    logic [VGP_DW-1:0]        rd_byte;

    // address decode
    always_comb begin
        b0_hit   = vgp_in_range(ctl_req.addr, BANK0_BASE, VGP_BANK_REGS);
        b1_hit   = vgp_in_range(ctl_req.addr, BANK1_BASE, VGP_BANK_REGS);
        seed_hit = vgp_in_range(ctl_req.addr, SEED_BASE, VGP_SEED_REGS);
        b0_idx   = vgp_index(ctl_req.addr, BANK0_BASE);
        b1_idx   = vgp_index(ctl_req.addr, BANK1_BASE);
        seed_idx = vgp_index(ctl_req.addr, SEED_BASE);
    end

    // bank zero, 0x17 to 0x1F
    vgp_coef_bank u_bank0 (
        .core_clk (core_clk),
        .nrst     (nrst),
        .wr_en    (ctl_req.wr && b0_hit),
        .wr_idx   (b0_idx),
        .wr_data  (ctl_req.wdata),
        .regs     (b0_regs),
        .coef     (b0_coef)
    );

    // second bank, separate storage at 0x27 to 0x2F
    vgp_coef_bank u_bank1 (
        .core_clk (core_clk),
        .nrst     (nrst),
        .wr_en    (ctl_req.wr && b1_hit),
        .wr_idx   (b1_idx),
        .wr_data  (ctl_req.wdata),
        .regs     (b1_regs),
        .coef     (b1_coef)
    );

    // read mux; unmapped and reserved offsets answer zero
    always_comb begin
        if (b0_hit) begin
            rd_byte = b0_regs[b0_idx];
        end else if (b1_hit) begin
            rd_byte = b1_regs[b1_idx];
        end else if (seed_hit) begin
            rd_byte = st.seed[seed_idx[1:0]];
        end else begin
            rd_byte = VGP_REG_RESET;
        end
    end

    always_comb begin
        next_st = st;
        next_st.rsp.rvalid = ctl_req.rd;
        if (ctl_req.rd) begin
            next_st.rsp.rdata = rd_byte;
        end
        // reserved seed bits are dropped so they never leak into the seed
        if (ctl_req.wr && seed_hit) begin
            next_st.seed[seed_idx[1:0]] =
                ctl_req.wdata & SEED_WMASK[seed_idx[1:0]];
        end
        // the pin picks a stored set; registering it avoids mid-cycle mixes
        if (buffer_sel) begin
            next_st.coef_out = b1_coef;
        end else begin
            next_st.coef_out = b0_coef;
        end
        next_st.bank_out = buffer_sel;
        next_st.seed_out = {st.seed[3], st.seed[2], st.seed[1],
                            st.seed[0][SEED_LO_LSB +: 4]};
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        ctl_rsp  = st.rsp;
        coef_out = st.coef_out;
        seed_out = st.seed_out;
        bank_out = st.bank_out;
    end

    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    property p_bank0_applied;
        !buffer_sel |=> (coef_out == $past(b0_coef)) && !bank_out;
    endproperty
    a_bank0_applied: assert property (p_bank0_applied)
        else $error("bank zero not applied while select low");

    property p_bank1_applied;
        buffer_sel |=> (coef_out == $past(b1_coef)) && bank_out;
    endproperty
    a_bank1_applied: assert property (p_bank1_applied)
        else $error("second bank not applied while select high");

    property p_msync_low;
        (ctl_req.wr && ctl_req.addr == MSYNC_GAIN_LOW && !buffer_sel)
            ##1 !buffer_sel
        |=> coef_out.mixed_sync_scale[7:0] == $past(ctl_req.wdata, 2);
    endproperty
    a_msync_low: assert property (p_msync_low)
        else $error("mixed sync gain low byte wrong");

    property p_msync_high;
        (ctl_req.wr && ctl_req.addr == OFFSET_MSYNC_HIGH && !buffer_sel)
            ##1 !buffer_sel
        |=> coef_out.mixed_sync_scale[9:8] == $past(ctl_req.wdata[1:0], 2);
    endproperty
    a_msync_high: assert property (p_msync_high)
        else $error("mixed sync gain top bits wrong");

    property p_luma_low;
        (ctl_req.wr && ctl_req.addr == LUMA_GAIN_LOW && !buffer_sel)
            ##1 !buffer_sel
        |=> coef_out.luma_gain_coef[7:0] == $past(ctl_req.wdata, 2);
    endproperty
    a_luma_low: assert property (p_luma_low)
        else $error("luma gain low byte wrong");

    property p_gain_high;
        (ctl_req.wr && ctl_req.addr == GAIN_HIGH_BITS && !buffer_sel)
            ##1 !buffer_sel
        |=> coef_out.luma_gain_coef[9:8] == $past(ctl_req.wdata[7:6], 2)
            && coef_out.u_chroma_gain[10:8] == $past(ctl_req.wdata[5:3], 2)
            && coef_out.v_chroma_gain[9:8] == $past(ctl_req.wdata[1:0], 2);
    endproperty
    a_gain_high: assert property (p_gain_high)
        else $error("gain top bits wrong");

    property p_u_low;
        (ctl_req.wr && ctl_req.addr == U_GAIN_LOW && !buffer_sel)
            ##1 !buffer_sel
        |=> coef_out.u_chroma_gain[7:0] == $past(ctl_req.wdata, 2);
    endproperty
    a_u_low: assert property (p_u_low)
        else $error("U gain low byte wrong");

    property p_v_low;
        (ctl_req.wr && ctl_req.addr == V_GAIN_LOW && !buffer_sel)
            ##1 !buffer_sel
        |=> coef_out.v_chroma_gain[7:0] == $past(ctl_req.wdata, 2);
    endproperty
    a_v_low: assert property (p_v_low)
        else $error("V gain low byte wrong");

    property p_offset_low;
        (ctl_req.wr && ctl_req.addr == LUMA_OFFSET_LOW && !buffer_sel)
            ##1 !buffer_sel
        |=> coef_out.luma_rgb_offset[7:0] == $past(ctl_req.wdata, 2);
    endproperty
    a_offset_low: assert property (p_offset_low)
        else $error("offset low byte wrong");

    property p_offset_high;
        (ctl_req.wr && ctl_req.addr == OFFSET_MSYNC_HIGH && !buffer_sel)
            ##1 !buffer_sel
        |=> coef_out.luma_rgb_offset[8] == $past(ctl_req.wdata[2], 2);
    endproperty
    a_offset_high: assert property (p_offset_high)
        else $error("offset top bit wrong");

    property p_phase_low_flip;
        (ctl_req.wr && ctl_req.addr == PHASE_LOW_VFLIP && !buffer_sel)
            ##1 !buffer_sel
        |=> coef_out.system_phase_offset[6:0] == $past(ctl_req.wdata[7:1], 2)
            && coef_out.pal_v_sign_flip == $past(ctl_req.wdata[0], 2);
    endproperty
    a_phase_low_flip: assert property (p_phase_low_flip)
        else $error("phase low bits or V flip wrong");

    property p_phase_high;
        (ctl_req.wr && ctl_req.addr == PHASE_HIGH && !buffer_sel)
            ##1 !buffer_sel
        |=> coef_out.system_phase_offset[14:7] == $past(ctl_req.wdata, 2);
    endproperty
    a_phase_high: assert property (p_phase_high)
        else $error("phase top byte wrong");

    property p_seed_low;
        ctl_req.wr && ctl_req.addr == SUBCARRIER_SEED_BITS_3_0
        |=> ##1 seed_out[3:0] == $past(ctl_req.wdata[7:4], 2);
    endproperty
    a_seed_low: assert property (p_seed_low)
        else $error("seed bits 3-0 wrong");

    property p_seed_mid;
        ctl_req.wr && ctl_req.addr == SUBCARRIER_SEED_BITS_11_4
        |=> ##1 seed_out[11:4] == $past(ctl_req.wdata, 2);
    endproperty
    a_seed_mid: assert property (p_seed_mid)
        else $error("seed bits 11-4 wrong");

    property p_seed_upper;
        ctl_req.wr && ctl_req.addr == SUBCARRIER_SEED_BITS_19_12
        |=> ##1 seed_out[19:12] == $past(ctl_req.wdata, 2);
    endproperty
    a_seed_upper: assert property (p_seed_upper)
        else $error("seed bits 19-12 wrong");

    property p_seed_top;
        ctl_req.wr && ctl_req.addr == SUBCARRIER_SEED_BITS_27_20
        |=> ##1 seed_out[27:20] == $past(ctl_req.wdata, 2);
    endproperty
    a_seed_top: assert property (p_seed_top)
        else $error("seed bits 27-20 wrong");

    property p_banks_kept;
        !(ctl_req.wr && (b0_hit || b1_hit))
        |=> $stable(b0_regs) && $stable(b1_regs);
    endproperty
    a_banks_kept: assert property (p_banks_kept)
        else $error("bank contents changed without a write");

    property p_reserved_read;
        ctl_req.rd && ctl_req.addr == GAIN_HIGH_BITS
        |=> ctl_rsp.rvalid && !ctl_rsp.rdata[2];
    endproperty
    a_reserved_read: assert property (p_reserved_read)
        else $error("reserved gain bit reads back set");

    property p_read_once;
        ctl_req.rd ##1 !ctl_req.rd |=> !ctl_rsp.rvalid;
    endproperty
    a_read_once: assert property (p_read_once)
        else $error("read answer held too long");

    property p_seed_reserved;
        ctl_req.rd && ctl_req.addr == SUBCARRIER_SEED_BITS_3_0
        |=> ctl_rsp.rvalid && ctl_rsp.rdata[3:0] == 4'h0;
    endproperty
    a_seed_reserved: assert property (p_seed_reserved)
        else $error("reserved seed bits read back set");

    property p_offset_reserved;
        ctl_req.rd && ctl_req.addr == OFFSET_MSYNC_HIGH
        |=> ctl_rsp.rvalid && ctl_rsp.rdata[7:3] == 5'h00;
    endproperty
    a_offset_reserved: assert property (p_offset_reserved)
        else $error("reserved offset bits read back set");

    // a write into one bank must leave the other bank untouched
    property p_bank1_kept;
        ctl_req.wr && b0_hit |=> $stable(b1_regs);
    endproperty
    a_bank1_kept: assert property (p_bank1_kept)
        else $error("second bank changed by a bank zero write");

    property p_bank0_kept;
        ctl_req.wr && b1_hit |=> $stable(b0_regs);
    endproperty
    a_bank0_kept: assert property (p_bank0_kept)
        else $error("bank zero changed by a second bank write");

    // the seed output lags its bytes by one edge
    property p_seed_kept;
        !(ctl_req.wr && seed_hit) |=> ##1 $stable(seed_out);
    endproperty
    a_seed_kept: assert property (p_seed_kept)
        else $error("seed changed without a seed write");

    property p_msync_joined;
        !buffer_sel
        |=> coef_out.mixed_sync_scale[9:8] == $past(b0_regs[6][1:0])
            && coef_out.mixed_sync_scale[7:0] == $past(b0_regs[0]);
    endproperty
    a_msync_joined: assert property (p_msync_joined)
        else $error("mixed sync gain not joined from its bytes");

    property p_phase_joined;
        !buffer_sel
        |=> coef_out.system_phase_offset[14:7] == $past(b0_regs[8])
            && coef_out.system_phase_offset[6:0] == $past(b0_regs[7][7:1]);
    endproperty
    a_phase_joined: assert property (p_phase_joined)
        else $error("phase offset not joined from its bytes");

    property p_vflip_joined;
        !buffer_sel
        |=> coef_out.pal_v_sign_flip == $past(b0_regs[7][0]);
    endproperty
    a_vflip_joined: assert property (p_vflip_joined)
        else $error("V flip not taken from its bit");

endmodule : vgp_regs
`default_nettype wire

/* tb/vgp_host_model.sv */
// host controller model driving the register control port
`timescale 1ns/1ps
`default_nettype none
module vgp_host_model
    import vgp_pkg::*;
(
    // clock
    input  wire logic                  core_clk,
    // control port
    output var  vgp_pkg::vgp_ctl_req_t ctl_req,
    input  wire vgp_pkg::vgp_ctl_rsp_t ctl_rsp
);

    initial begin
        ctl_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h5A, wdata: 8'hA5};
    end

    // reserved bits are sent as zero
    function automatic logic [7:0] keep_mask(input logic [7:0] a);
        case (a)
            8'h1B, 8'h2B: return 8'hFB;
            8'h1D, 8'h2D: return 8'h07;
            8'h20:        return 8'hF0;
            default:      return 8'hFF;
        endcase
    endfunction : keep_mask

    // lines left idle show the inverse of the last value, never a stale copy
    task automatic release_bus();
        ctl_req.wr    = 1'b0;
        ctl_req.rd    = 1'b0;
        ctl_req.addr  = ~ctl_req.addr;
        ctl_req.wdata = ~ctl_req.wdata;
    endtask : release_bus

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        ctl_req.addr  = a;
        ctl_req.wdata = d & keep_mask(a);
        ctl_req.wr    = 1'b1;
        @(negedge core_clk);
        release_bus();
    endtask : write_reg

    // one strobe cycle, then wait a bounded time for the answer
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                            output logic ok);
        ok = 1'b0;
        d  = 8'h00;
        @(negedge core_clk);
        ctl_req.addr = a;
        ctl_req.rd   = 1'b1;
        @(negedge core_clk);
        release_bus();
        for (int i = 0; i < 3 && !ok; i++) begin
            if (ctl_rsp.rvalid === 1'b1) begin
                ok = 1'b1;
                d  = ctl_rsp.rdata;
            end else begin
                @(negedge core_clk);
            end
        end
    endtask : read_reg

endmodule : vgp_host_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the coefficient bank and seed registers
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("unexpected at %0t got %h expected %h", $time, g, e); \
    end \
end
module tb_top;
    import vgp_pkg::*;

    logic                  core_clk;
    logic                  nrst;
    logic                  buffer_sel;
    vgp_ctl_req_t          ctl_req;
    vgp_ctl_rsp_t          ctl_rsp;
    vgp_coef_t             coef_out;
    logic [27:0]           seed_out;
    logic                  bank_out;
    int                    fail_count;
    int                    n_tests;
    logic [7:0]            bank0 [9];
    logic [7:0]            bank1 [9];
    logic [7:0]            seedb [4];

    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;

    vgp_regs u_dut (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .buffer_sel (buffer_sel),
        .ctl_req    (ctl_req),
        .ctl_rsp    (ctl_rsp),
        .coef_out   (coef_out),
        .seed_out   (seed_out),
        .bank_out   (bank_out)
    );

    vgp_host_model u_host (
        .core_clk (core_clk),
        .ctl_req  (ctl_req),
        .ctl_rsp  (ctl_rsp)
    );

    // expected joined coefficients, worked out bit by bit from the bytes
    function automatic vgp_coef_t exp_coef(input logic [7:0] b [9]);
        vgp_coef_t c;
        c.mixed_sync_scale    = {b[6][1:0], b[0]};
        c.luma_gain_coef      = {b[4][7:6], b[1]};
        c.u_chroma_gain       = {b[4][5:3], b[2]};
        c.v_chroma_gain       = {b[4][1:0], b[3]};
        c.luma_rgb_offset     = {b[6][2], b[5]};
        c.system_phase_offset = {b[8], b[7][7:1]};
        c.pal_v_sign_flip     = b[7][0];
        return c;
    endfunction : exp_coef

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic check_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        u_host.read_reg(a, d, ok);
        if (ok !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t got %h expected %h", $time, ok, 1);
            complete_run();
        end
        `CHECK(d, e)
    endtask : check_rd

    task automatic load(input logic [7:0] base, input logic [7:0] b [9]);
        for (int i = 0; i < 9; i++) begin
            u_host.write_reg(base + 8'(i), b[i]);
        end
        repeat (2) @(negedge core_clk);
    endtask : load

    initial begin
        bank0 = '{8'hA5, 8'h3C, 8'h5A, 8'hC3, 8'hF9, 8'h81, 8'h05, 8'hB7,
                  8'h6E};
        bank1 = '{8'h5A, 8'hC3, 8'h96, 8'h3C, 8'h6A, 8'h7E, 8'h02, 8'h48,
                  8'hD1};
        seedb = '{8'hD0, 8'h34, 8'h56, 8'h9A};
        fail_count = 0;
        n_tests    = 0;
        nrst       = 1'b0;
        buffer_sel = 1'b0;
        repeat (5) @(negedge core_clk);
        nrst = 1'b1;
        @(negedge core_clk);

        // bank zero and seed registers come up cleared
        `CHECK(coef_out, '0)
        `CHECK(seed_out, 28'h0)
        for (int i = 0; i < 13; i++) begin
            check_rd(BANK0_BASE + 8'(i), 8'h00);
        end
        $display("test reset done");

        // bank zero fields, each assembled from its split bytes
        load(BANK0_BASE, bank0);
        `CHECK(coef_out.mixed_sync_scale, 10'h1A5)
        `CHECK(coef_out.mixed_sync_scale[9:8], bank0[6][1:0])
        `CHECK(coef_out.luma_gain_coef, 10'h33C)
        `CHECK(coef_out.luma_gain_coef[9:8], bank0[4][7:6])
        `CHECK(coef_out.u_chroma_gain[7:0], bank0[2])
        `CHECK(coef_out.u_chroma_gain, 11'h75A)
        `CHECK(coef_out.v_chroma_gain[7:0], bank0[3])
        `CHECK(coef_out.v_chroma_gain, 10'h1C3)
        `CHECK(coef_out.luma_rgb_offset[7:0], bank0[5])
        `CHECK(coef_out.luma_rgb_offset, 9'h181)
        `CHECK(coef_out.system_phase_offset[6:0], bank0[7][7:1])
        `CHECK(coef_out.system_phase_offset, 15'h375B)
        `CHECK(coef_out.pal_v_sign_flip, 1'b1)
        `CHECK(coef_out, exp_coef(bank0))
        `CHECK(bank_out, 1'b0)
        for (int i = 0; i < 9; i++) begin
            check_rd(BANK0_BASE + 8'(i), bank0[i]);
        end
        $display("test bank zero done");

        // second bank written while low must not reach the outputs
        load(BANK1_BASE, bank1);
        `CHECK(coef_out, exp_coef(bank0))
        buffer_sel = 1'b1;
        repeat (2) @(negedge core_clk);
        `CHECK(coef_out, exp_coef(bank1))
        `CHECK(coef_out.pal_v_sign_flip, 1'b0)
        `CHECK(bank_out, 1'b1)
        // bank zero edited while high stays hidden until select drops
        bank0[0] = 8'h3E;
        u_host.write_reg(MSYNC_GAIN_LOW, bank0[0]);
        repeat (2) @(negedge core_clk);
        `CHECK(coef_out, exp_coef(bank1))
        buffer_sel = 1'b0;
        repeat (2) @(negedge core_clk);
        `CHECK(coef_out, exp_coef(bank0))
        `CHECK(bank_out, 1'b0)
        buffer_sel = 1'b1;
        repeat (2) @(negedge core_clk);
        `CHECK(coef_out, exp_coef(bank1))
        buffer_sel = 1'b0;
        for (int i = 0; i < 9; i++) begin
            check_rd(BANK1_BASE + 8'(i), bank1[i]);
        end
        $display("test bank switch done");

        // subcarrier seed across four bytes
        for (int i = 0; i < 4; i++) begin
            u_host.write_reg(SEED_BASE + 8'(i), seedb[i]);
        end
        repeat (2) @(negedge core_clk);
        `CHECK(seed_out[3:0], seedb[0][7:4])
        `CHECK(seed_out[11:4], seedb[1])
        `CHECK(seed_out[19:12], seedb[2])
        `CHECK(seed_out[27:20], seedb[3])
        `CHECK(seed_out, 28'h9A5634D)
        check_rd(SUBCARRIER_SEED_BITS_27_20, 8'h9A);
        check_rd(8'h24, 8'h00);
        check_rd(8'h10, 8'h00);
        $display("test seed done");

        complete_run();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        $display("unexpected at %0t got %h expected %h", $time, 0, 1);
        complete_run();
    end

endmodule : tb_top
`default_nettype wire
